// ### dfm_pkg.sv
package dfm_pkg;
    // Emergency codes
    localparam logic [15:0] CODE_MAP_LEN = 16'h6262;
    localparam logic [15:0] CODE_MAP_ATTR = 16'h6263;
    localparam logic [15:0] CODE_MAP_PTR = 16'h6264;
    localparam logic [15:0] CODE_MAP_MISSING = 16'h6265;
    localparam logic [15:0] CODE_MAP_TOO_LONG = 16'h6266;
    localparam logic [15:0] CODE_POS_FACTOR = 16'h6341;
    localparam logic [15:0] CODE_SECTION_DIV = 16'h6342;
    localparam logic [15:0] CODE_RAMP_LONG = 16'h6343;
    localparam logic [15:0] CODE_MODE_REFUSED = 16'h6345;
    localparam logic [15:0] CODE_ACCEL_CLAMP = 16'h6348;
    localparam logic [15:0] CODE_MAIN_ENC = 16'h7300;
    localparam logic [15:0] CODE_RED_ENC = 16'h731F;
    localparam int NUM_COND = 12;
    // Condition indices
    localparam int C_MAP_LEN = 0;
    localparam int C_MAP_ATTR = 1;
    localparam int C_MAP_PTR = 2;
    localparam int C_MAP_MISSING = 3;
    localparam int C_MAP_TOO_LONG = 4;
    localparam int C_POS_FACTOR = 5;
    localparam int C_SECTION_DIV = 6;
    localparam int C_RAMP_LONG = 7;
    localparam int C_MODE_REFUSED = 8;
    localparam int C_ACCEL_CLAMP = 9;
    localparam int C_MAIN_ENC = 10;
    localparam int C_RED_ENC = 11;
    // Mapping and section figures
    localparam logic [7:0] MAP_MAX_BYTES = 8'h08;
    localparam logic [16:0] MAX_SECTION_REVS = 17'h1_0000;
    localparam logic [4:0] MAX_SECTION_LOG2 = 5'h10;
    localparam logic [31:0] MIN_POS_UNITS = 32'h0000_0002;
    // Acceleration floor, 27,9 rpm held in tenths of rpm
    localparam logic [15:0] ACCEL_MIN_DRPM = 16'h0117;
    // Encoder consecutive read fault limit
    localparam logic [7:0] ENC_FAIL_LIMIT = 8'h08;
    localparam int FAULT_ACK_BIT = 7;
    localparam logic [NUM_COND-1:0] COND_RESET = 12'h000;
    localparam logic [7:0] CNT_RESET = 8'h00;
endpackage

// ### dfm_enc_counter.sv
`timescale 1ns/1ps
module dfm_enc_counter
    import dfm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic read_done,
    input wire logic read_fail,
    output logic limit_hit
);
    logic [7:0] fail_cnt_r;

    // Count consecutive failures, good read restarts
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fail_cnt_r <= CNT_RESET;
        end else if (read_done) begin
            if (!read_fail) begin
                fail_cnt_r <= CNT_RESET;
            end else if (fail_cnt_r != ENC_FAIL_LIMIT) begin
                fail_cnt_r <= fail_cnt_r + 8'h01;
            end
        end
    end

    assign limit_hit = read_done && read_fail && (fail_cnt_r == ENC_FAIL_LIMIT - 8'h01);
endmodule // dfm_enc_counter

// ### dfm_monitor.sv
`timescale 1ns/1ps
module dfm_monitor
    import dfm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [15:0] drive_control_word,
    input wire logic map_check_valid,
    input wire logic map_len_diff,
    input wire logic map_attr_diff,
    input wire logic map_ptr_diff,
    input wire logic map_obj_missing,
    input wire logic [7:0] map_total_bytes,
    input wire logic comm_settings_default_load,
    input wire logic node_reset_cmd,
    input wire logic gear_enabled,
    input wire logic [16:0] gear_max_section_revs,
    input wire logic section_check,
    input wire logic [16:0] section_revs,
    input wire logic [31:0] pos_factor,
    input wire logic [31:0] pos_lower_limit,
    input wire logic [31:0] pos_upper_limit,
    input wire logic ramp_too_long,
    input wire logic mode_change_refused,
    input wire logic enable_mode_unsupported,
    input wire logic enable_success,
    input wire logic accel_set,
    input wire logic [15:0] accel_limit,
    input wire logic [15:0] decel_limit,
    input wire logic main_enc_done,
    input wire logic main_enc_fail,
    input wire logic [3:0] red_enc_done,
    input wire logic [3:0] red_enc_fail,
    output logic [16:0] section_revs_used,
    output logic [31:0] section_units,
    output logic [15:0] accel_used,
    output logic [15:0] decel_used,
    output logic [NUM_COND-1:0] cond_active,
    output logic emcy_valid,
    input wire logic emcy_ready,
    output logic [15:0] emcy_code
);
    logic [NUM_COND-1:0] active_r;
    logic [NUM_COND-1:0] pending_r;
    logic [NUM_COND-1:0] detect;
    logic [NUM_COND-1:0] clear;
    logic [NUM_COND-1:0] send_sel;
    logic [16:0] section_revs_r;
    logic [31:0] section_units_r;
    logic [15:0] accel_r;
    logic [15:0] decel_r;
    logic [15:0] emcy_code_r;
    logic emcy_valid_r;
    logic default_loaded_r;
    logic [16:0] max_revs;
    logic [16:0] rounded_revs;
    logic [47:0] units_prod;
    logic [31:0] units_calc;
    logic fault_ack;
    logic accel_low;
    logic main_hit;
    logic [3:0] red_hit;
    logic [15:0] code_tbl [NUM_COND];

    assign fault_ack = drive_control_word[FAULT_ACK_BIT];

    assign max_revs = gear_enabled ? gear_max_section_revs : MAX_SECTION_REVS;

    // round to nearest power of two, at most MAX_SECTION_REVS
    always_comb begin
        rounded_revs = 17'h0_0001;
        for (int i = 1; i <= int'(MAX_SECTION_LOG2); i++) begin
            if (section_revs >= ((17'h0_0001 << (i - 1)) + (17'h0_0001 << (i - 2 < 0 ? 0 : i - 2))))
                rounded_revs = 17'h0_0001 << i;
        end
        if (section_revs == 17'h0_0000)
            rounded_revs = 17'h0_0001;
    end

    assign units_calc = pos_upper_limit - pos_lower_limit + 32'h0000_0001;
    assign units_prod = {31'h0000_0000, max_revs} * {16'h0000, pos_factor};

    assign accel_low = (accel_limit < ACCEL_MIN_DRPM) || (decel_limit < ACCEL_MIN_DRPM);

    dfm_enc_counter u_main (
        .clk_sys(clk_sys),
        .reset(reset),
        .read_done(main_enc_done),
        .read_fail(main_enc_fail),
        .limit_hit(main_hit)
    );

    for (genvar g = 0; g < 4; g++) begin : g_red
        dfm_enc_counter u_red (
            .clk_sys(clk_sys),
            .reset(reset),
            .read_done(red_enc_done[g]),
            .read_fail(red_enc_fail[g]),
            .limit_hit(red_hit[g])
        );
    end

    always_comb begin
        detect = COND_RESET;
        detect[C_MAP_LEN] = map_check_valid && map_len_diff;
        detect[C_MAP_ATTR] = map_check_valid && map_attr_diff;
        detect[C_MAP_PTR] = map_check_valid && map_ptr_diff;
        detect[C_MAP_MISSING] = map_check_valid && map_obj_missing;
        detect[C_MAP_TOO_LONG] = map_check_valid && (map_total_bytes > MAP_MAX_BYTES);
        detect[C_POS_FACTOR] = section_check && (units_prod < {16'h0000, MIN_POS_UNITS});
        detect[C_SECTION_DIV] = section_check && !gear_enabled && (section_revs != rounded_revs);
        detect[C_RAMP_LONG] = ramp_too_long;
        detect[C_MODE_REFUSED] = mode_change_refused || enable_mode_unsupported;
        detect[C_ACCEL_CLAMP] = accel_set && accel_low;
        detect[C_MAIN_ENC] = main_hit;
        detect[C_RED_ENC] = |red_hit;
    end

    always_comb begin
        clear = COND_RESET;
        for (int i = C_MAP_LEN; i <= C_MAP_TOO_LONG; i++)
            clear[i] = node_reset_cmd && default_loaded_r;
        clear[C_POS_FACTOR] = fault_ack && !section_check;
        clear[C_SECTION_DIV] = fault_ack && !section_check;
        clear[C_RAMP_LONG] = fault_ack && !ramp_too_long;
        clear[C_MODE_REFUSED] = enable_success;
        clear[C_ACCEL_CLAMP] = accel_set && !accel_low;
    end

    // Default comm settings must precede node reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            default_loaded_r <= 1'b0;
        end else if (node_reset_cmd) begin
            default_loaded_r <= 1'b0;
        end else if (comm_settings_default_load) begin
            default_loaded_r <= 1'b1;
        end
    end

    // Sticky conditions, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            active_r <= COND_RESET;
        end else begin
            active_r <= (active_r & ~clear) | detect;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            section_revs_r <= 17'h0_0001;
            section_units_r <= 32'h0000_0001;
        end else if (section_check) begin
            section_revs_r <= gear_enabled ? section_revs : rounded_revs;
            section_units_r <= units_calc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            accel_r <= ACCEL_MIN_DRPM;
            decel_r <= ACCEL_MIN_DRPM;
        end else if (accel_set) begin
            accel_r <= (accel_limit < ACCEL_MIN_DRPM) ? ACCEL_MIN_DRPM : accel_limit;
            decel_r <= (decel_limit < ACCEL_MIN_DRPM) ? ACCEL_MIN_DRPM : decel_limit;
        end
    end

    assign code_tbl[C_MAP_LEN] = CODE_MAP_LEN;
    assign code_tbl[C_MAP_ATTR] = CODE_MAP_ATTR;
    assign code_tbl[C_MAP_PTR] = CODE_MAP_PTR;
    assign code_tbl[C_MAP_MISSING] = CODE_MAP_MISSING;
    assign code_tbl[C_MAP_TOO_LONG] = CODE_MAP_TOO_LONG;
    assign code_tbl[C_POS_FACTOR] = CODE_POS_FACTOR;
    assign code_tbl[C_SECTION_DIV] = CODE_SECTION_DIV;
    assign code_tbl[C_RAMP_LONG] = CODE_RAMP_LONG;
    assign code_tbl[C_MODE_REFUSED] = CODE_MODE_REFUSED;
    assign code_tbl[C_ACCEL_CLAMP] = CODE_ACCEL_CLAMP;
    assign code_tbl[C_MAIN_ENC] = CODE_MAIN_ENC;
    assign code_tbl[C_RED_ENC] = CODE_RED_ENC;

    // Lowest pending index goes first
    always_comb begin
        send_sel = COND_RESET;
        for (int i = NUM_COND - 1; i >= 0; i--) begin
            if (pending_r[i]) begin
                send_sel = COND_RESET;
                send_sel[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pending_r <= COND_RESET;
        end else begin
            pending_r <= (pending_r & ~((!emcy_valid_r) ? send_sel : COND_RESET)) | detect;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            emcy_valid_r <= 1'b0;
            emcy_code_r <= 16'h0000;
        end else if (emcy_valid_r) begin
            if (emcy_ready)
                emcy_valid_r <= 1'b0;
        end else if (|pending_r) begin
            emcy_valid_r <= 1'b1;
            for (int i = 0; i < NUM_COND; i++) begin
                if (send_sel[i])
                    emcy_code_r <= code_tbl[i];
            end
        end
    end

    assign section_revs_used = section_revs_r;
    assign section_units = section_units_r;
    assign accel_used = accel_r;
    assign decel_used = decel_r;
    assign cond_active = active_r;
    assign emcy_valid = emcy_valid_r;
    assign emcy_code = emcy_code_r;
endmodule // dfm_monitor

// ### dfm_checker.sv
`timescale 1ns/1ps
module dfm_checker
    import dfm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [15:0] drive_control_word,
    input wire logic map_check_valid,
    input wire logic [7:0] map_total_bytes,
    input wire logic gear_enabled,
    input wire logic section_check,
    input wire logic node_reset_cmd,
    input wire logic ramp_too_long,
    input wire logic mode_change_refused,
    input wire logic enable_mode_unsupported,
    input wire logic enable_success,
    input wire logic accel_set,
    input wire logic [15:0] accel_limit,
    input wire logic [16:0] section_revs_used,
    input wire logic [15:0] accel_used,
    input wire logic [dfm_pkg::NUM_COND-1:0] cond_active,
    input wire logic emcy_valid,
    input wire logic emcy_ready,
    input wire logic [15:0] emcy_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    emcy_hold_a: assert property (
        emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_code)) else $error("emcy dropped");
    emcy_drop_a: assert property (
        emcy_valid && emcy_ready |=> !emcy_valid) else $error("emcy not released");
    map_long_a: assert property (
        map_check_valid && map_total_bytes > MAP_MAX_BYTES |=> cond_active[C_MAP_TOO_LONG])
        else $error("long map missed");
    map_hold_a: assert property (
        cond_active[C_MAP_LEN] && !node_reset_cmd |=> cond_active[C_MAP_LEN])
        else $error("map code lost");
    revs_pow2_a: assert property (
        section_check && !gear_enabled
        |=> section_revs_used != 17'h0_0000 && section_revs_used <= MAX_SECTION_REVS
        && (section_revs_used & (section_revs_used - 17'h0_0001)) == 17'h0_0000)
        else $error("section not power of two");
    ramp_set_a: assert property (
        ramp_too_long |=> cond_active[C_RAMP_LONG]) else $error("ramp missed");
    ramp_ack_a: assert property (
        drive_control_word[FAULT_ACK_BIT] && !ramp_too_long |=> !cond_active[C_RAMP_LONG])
        else $error("ramp not cleared");
    mode_clear_a: assert property (
        enable_success && !mode_change_refused && !enable_mode_unsupported
        |=> !cond_active[C_MODE_REFUSED]) else $error("mode warning kept");
    accel_floor_a: assert property (
        accel_set && accel_limit < ACCEL_MIN_DRPM
        |=> accel_used == ACCEL_MIN_DRPM && cond_active[C_ACCEL_CLAMP]) else $error("no clamp");
    enc_sticky_a: assert property (
        cond_active[C_MAIN_ENC] |=> cond_active[C_MAIN_ENC]) else $error("encoder fault lost");
    cover property (emcy_valid && emcy_ready);
    cover property ($rose(cond_active[C_ACCEL_CLAMP]));
    cover property ($rose(cond_active[C_MAIN_ENC]));
    cover property (section_check && gear_enabled);
endmodule // dfm_checker
bind dfm_monitor dfm_checker u_chk (.*);

// ### dfm_master_model.sv
`timescale 1ns/1ps
module dfm_master_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [2:0] delay,
    input wire logic emcy_valid,
    output logic emcy_ready
);
    logic [2:0] wait_r;
    always_ff @(posedge clk_sys) begin
        if (reset || !emcy_valid || emcy_ready) begin
            emcy_ready <= 1'b0;
            wait_r <= 3'h0;
        end else if (wait_r >= delay) begin
            emcy_ready <= 1'b1;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end
endmodule // dfm_master_model

// ### test_drive_fault_code_monitor.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module test_drive_fault_code_monitor;
    import dfm_pkg::*;
    logic clk_sys = 0, reset = 1, gear_enabled = 0, emcy_valid, emcy_ready;
    logic map_check_valid, map_len_diff, map_attr_diff, map_ptr_diff, map_obj_missing;
    logic comm_settings_default_load, node_reset_cmd, mode_change_refused, ramp_too_long;
    logic enable_mode_unsupported, enable_success, section_check, accel_set;
    logic main_enc_done = 0, main_enc_fail = 0;
    logic [3:0] red_enc_done = 0, red_enc_fail = 0;
    logic [4:0] mv = 0;
    logic [8:0] pv = 0;
    logic [7:0] map_total_bytes = 0;
    logic [15:0] drive_control_word, accel_limit = 0, decel_limit = 0, accel_used, decel_used;
    logic [15:0] emcy_code, got[$];
    logic [16:0] gear_max_section_revs = 0, section_revs = 1, section_revs_used, sv;
    logic [31:0] pos_factor = 1, pos_lower_limit = 0, pos_upper_limit = 0, section_units;
    logic [31:0] seed = 7, lo;
    logic [NUM_COND-1:0] cond_active;
    logic [2:0] dly = 0;
    int error_cnt = 0, cmp_count = 0, cyc = 0, i;
    assign {map_check_valid, map_len_diff, map_attr_diff, map_ptr_diff, map_obj_missing} = mv;
    assign {ramp_too_long, accel_set, section_check, enable_success} = {pv[8], pv[6:4]};
    assign {enable_mode_unsupported, mode_change_refused} = pv[3:2];
    assign {node_reset_cmd, comm_settings_default_load} = pv[1:0];
    assign drive_control_word = {8'h00, pv[7], 7'h00};
    dfm_monitor u_dut (.*);
    dfm_master_model u_master (.clk_sys, .reset, .delay(dly), .emcy_valid, .emcy_ready);
    always #20 clk_sys = ~clk_sys;
    task test_done();
        if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (emcy_valid === 1'b1 && emcy_ready === 1'b1) got.push_back(emcy_code);
        if (cyc == 6000) begin
            error_cnt++;
            test_done();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Nearest power of two up to 65536, ties upward, zero to one
    function automatic int exp_revs(input int s);
        int best;
        int p;
        best = 1;
        for (int k = 1; k <= 16; k++) begin
            p = 1 << k;
            if (((s > p) ? s - p : p - s) <= ((s > best) ? s - best : best - s)) best = p;
        end
        return best;
    endfunction
    task pulse(input int k);
        @(posedge clk_sys);
        pv[k] <= 1'b1;
        dly <= 3'(rnd());
        @(posedge clk_sys);
        pv[k] <= 1'b0;
    endtask
    task chk(input int b, input logic e);
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK("cond_active", e, cond_active[b])
    endtask
    task take(input logic [15:0] c);
        logic [15:0] v;
        for (int k = 0; k < 300 && got.size() == 0; k++) @(posedge clk_sys);
        #1;
        v = (got.size() == 0) ? 16'h0000 : got.pop_front();
        `CHK("emcy_code", c, v)
    endtask
    task enc(input int n, input int r, input logic f);
        repeat (n) begin
            @(posedge clk_sys);
            if (r < 0) {main_enc_done, main_enc_fail} <= {1'b1, f};
            else {red_enc_done[r], red_enc_fail[r]} <= {1'b1, f};
            @(posedge clk_sys);
            {main_enc_done, main_enc_fail, red_enc_done, red_enc_fail} <= 10'h000;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        mv <= 5'h1f;
        map_total_bytes <= 8'h09;
        @(posedge clk_sys);
        mv <= 5'h00;
        for (i = 0; i < 5; i++) take(CODE_MAP_LEN + 16'(i));
        pulse(1);
        chk(C_MAP_LEN, 1'b1);
        pulse(0);
        pulse(1);
        chk(C_MAP_TOO_LONG, 1'b0);
        @(posedge clk_sys);
        lo = rnd() & 32'h00ff_ffff;
        pos_lower_limit <= lo;
        pos_upper_limit <= lo + 32'h0000_ffff + (rnd() & 32'h0000_ffff);
        section_revs <= MAX_SECTION_REVS;
        gear_max_section_revs <= 17'(rnd());
        pulse(5);
        chk(C_SECTION_DIV, 1'b0);
        `CHK("units", pos_upper_limit - pos_lower_limit + 32'h0000_0001, section_units)
        `CHK("revs", MAX_SECTION_REVS, section_revs_used)
        @(posedge clk_sys);
        section_revs <= 17'h0_0005;
        pos_factor <= 32'h0000_0000;
        pulse(5);
        chk(C_POS_FACTOR, 1'b1);
        `CHK("div", 1'b1, cond_active[C_SECTION_DIV])
        `CHK("revs", 17'h0_0004, section_revs_used)
        take(CODE_POS_FACTOR);
        take(CODE_SECTION_DIV);
        pulse(7);
        chk(C_SECTION_DIV, 1'b0);
        @(posedge clk_sys);
        sv = 17'(rnd());
        section_revs <= sv;
        pos_factor <= 32'h0000_0001;
        pulse(5);
        chk(C_SECTION_DIV, sv != exp_revs(sv));
        `CHK("revs", exp_revs(sv), section_revs_used)
        `CHK("factor", 1'b0, cond_active[C_POS_FACTOR])
        if (sv != exp_revs(sv)) take(CODE_SECTION_DIV);
        pulse(7);
        chk(C_SECTION_DIV, 1'b0);
        @(posedge clk_sys);
        gear_enabled <= 1'b1;
        gear_max_section_revs <= 17'h0_0001;
        section_revs <= 17'h0_0005;
        pulse(5);
        chk(C_POS_FACTOR, 1'b1);
        `CHK("div", 1'b0, cond_active[C_SECTION_DIV])
        `CHK("revs", 17'h0_0005, section_revs_used)
        take(CODE_POS_FACTOR);
        @(posedge clk_sys);
        gear_enabled <= 1'b0;
        pulse(7);
        chk(C_POS_FACTOR, 1'b0);
        for (i = 2; i < 4; i++) begin
            pulse(i);
            chk(C_MODE_REFUSED, 1'b1);
            take(CODE_MODE_REFUSED);
            pulse(4);
            chk(C_MODE_REFUSED, 1'b0);
        end
        @(posedge clk_sys);
        accel_limit <= 16'(rnd()) % ACCEL_MIN_DRPM;
        decel_limit <= ACCEL_MIN_DRPM + (16'(rnd()) & 16'h03ff);
        pulse(6);
        chk(C_ACCEL_CLAMP, 1'b1);
        `CHK("accel", ACCEL_MIN_DRPM, accel_used)
        `CHK("decel", decel_limit, decel_used)
        take(CODE_ACCEL_CLAMP);
        @(posedge clk_sys);
        accel_limit <= ACCEL_MIN_DRPM;
        pulse(6);
        chk(C_ACCEL_CLAMP, 1'b0);
        pulse(8);
        chk(C_RAMP_LONG, 1'b1);
        take(CODE_RAMP_LONG);
        pulse(7);
        chk(C_RAMP_LONG, 1'b0);
        enc(7, -1, 1'b1);
        enc(1, -1, 1'b0);
        enc(7, -1, 1'b1);
        chk(C_MAIN_ENC, 1'b0);
        enc(1, -1, 1'b1);
        chk(C_MAIN_ENC, 1'b1);
        take(CODE_MAIN_ENC);
        enc(8, int'(rnd() % 4), 1'b1);
        chk(C_RED_ENC, 1'b1);
        take(CODE_RED_ENC);
        repeat (50) @(posedge clk_sys);
        `CHK("spare", 0, got.size())
        test_done();
    end
endmodule // test_drive_fault_code_monitor
